// ### core/ftm_pkg.sv
package ftm_pkg;
  // ****************************************
  // register map
  // ****************************************
  // entry offsets step by one: they are indices, byte address is index times four
  localparam int ADDR_W = 18;
  localparam logic [15:0] MAP_BASE_IDX = 16'hf300;
  localparam logic [15:0] MAP_LAST_IDX = 16'hf33f;
  localparam int MAP_COUNT = 64;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // channels and frame
  // ****************************************
  localparam int CHAN_COUNT = 16;
  localparam logic [5:0] CHAN_BASE = 6'h20;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [6:0] SLOT_LIMIT = 7'h40;
  localparam logic [3:0] LANE_TOP = 4'h8;
  localparam logic [3:0] LAST_CHAN = 4'hf;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // pin index in the synchroniser vector
  localparam int PIN_BCLK = 0;
  localparam int PIN_FSYNC = 1;
  localparam int PIN_A = 2;
  localparam int PIN_B = 3;

  // entry layout: bit 7 enable, 6 reverse, 5 pin, 4:2 channel, 1:0 byte lane
  typedef struct packed {
    logic enable;
    logic reverse;
    logic pin_sel;
    logic [2:0] chan_pos;
    logic [1:0] byte_pos;
  } ftm_map_entry_t;

  typedef struct packed {
    logic [5:0] chan;
    logic [31:0] data;
  } ftm_chan_word_t;

  typedef enum logic {
    FTM_IDLE = 1'b0,
    FTM_DRAIN = 1'b1
  } ftm_drain_t;
endpackage : ftm_pkg

// ### core/ftm_chan_ram.sv
`timescale 1ns/10ps
module ftm_chan_ram (
  input wire logic i_clock,
  input wire logic i_we,
  input wire logic [3:0] i_be,
  input wire logic [3:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic i_re,
  input wire logic [3:0] i_raddr,
  output logic [31:0] o_rdata
);
  logic [31:0] rdata_q;

  // later writes overwrite earlier ones; untouched lanes keep their bytes
  // one array per lane, so that no storage is written by two processes
  for (genvar g = 0; g < 4; g++) begin : g_lane
    logic [7:0] lane_mem [ftm_pkg::CHAN_COUNT];

    always_ff @(posedge i_clock) begin
      if (i_we && i_be[g]) begin // RQ8
        lane_mem[i_waddr] <= i_wdata[g*8 +: 8];
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_re) begin
        rdata_q[g*8 +: 8] <= lane_mem[i_raddr];
      end
    end
  end

  assign o_rdata = rdata_q;
endmodule : ftm_chan_ram

// ### core/ftm_mapper.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Operation
// [RQ1] Sixty-four slot entries each steer one input byte, building sixteen 32-bit channels.
// [RQ2] Entries sit at consecutive indices from 0xf300 and reset to zero, so all slots are off.
// [RQ3] An entry with bit 7 set captures its slot byte; with it clear the byte is dropped.
// [RQ4] Bit 6 set stores the byte bit-mirrored, clear stores it as received.
// [RQ5] Bit 5 picks pin a for channels 32-39 or pin b for channels 40-47.
// [RQ6] Bits 4:2 add a position of zero to seven to the group base channel.
// [RQ7] Bits 1:0 pick the lane: 00 bits 31:24, 01 23:16, 10 15:8, 11 7:0.
// [RQ8] When enabled slots collide the highest slot wins and untargeted lanes hold.
module ftm_mapper (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_bit_clock,
  input wire logic i_frame_sync,
  input wire logic i_flex_input_pin_a,
  input wire logic i_flex_input_pin_b,
  input wire logic [ftm_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ftm_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic o_chan_valid,
  output ftm_pkg::ftm_chan_word_t o_chan_word,
  input wire logic i_chan_ready
);
  // ****************************************
  // register bus
  // ****************************************
  function automatic logic map_hit(input logic [ftm_pkg::ADDR_W-1:0] addr);
    map_hit = addr[1:0] == 2'h0 && addr[17:2] >= ftm_pkg::MAP_BASE_IDX
      && addr[17:2] <= ftm_pkg::MAP_LAST_IDX;
  endfunction : map_hit

  function automatic logic [5:0] map_slot(input logic [ftm_pkg::ADDR_W-1:0] addr);
    logic [15:0] off;
    off = addr[17:2] - ftm_pkg::MAP_BASE_IDX;
    map_slot = off[5:0];
  endfunction : map_slot

  ftm_pkg::ftm_map_entry_t map_q [ftm_pkg::MAP_COUNT];
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [ftm_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic do_write;

  assign do_write = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= ftm_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
    end else begin
      if (awready_q && i_s_axi_awvalid) begin
        awready_q <= 1'b0;
        awaddr_q <= i_s_axi_awaddr;
      end
      if (wready_q && i_s_axi_wvalid) begin
        wready_q <= 1'b0;
        wbyte_q <= i_s_axi_wdata[7:0];
        wlane_q <= i_s_axi_wstrb[0];
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= map_hit(awaddr_q) ? ftm_pkg::RESP_OKAY : ftm_pkg::RESP_SLVERR;
      end
      if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // only the low byte lane is backed; bits 31:8 are reserved
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < ftm_pkg::MAP_COUNT; i++) begin
        map_q[i] <= ftm_pkg::MAP_RESET; // RQ2
      end
    end else if (do_write && wlane_q && map_hit(awaddr_q)) begin
      map_q[map_slot(awaddr_q)] <= wbyte_q; // RQ2
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ftm_pkg::RESP_OKAY;
    end else if (arready_q && i_s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= map_hit(i_s_axi_araddr) ? {24'h0, map_q[map_slot(i_s_axi_araddr)]} : '0;
      rresp_q <= map_hit(i_s_axi_araddr) ? ftm_pkg::RESP_OKAY : ftm_pkg::RESP_SLVERR;
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready = wready_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;

  // ****************************************
  // serial input
  // ****************************************
  logic [3:0] pin_s1_q, pin_s2_q;
  logic bclk_prev_q, fs_prev_q, bclk_rise, fstart;
  logic [2:0] bit_cnt_q;
  logic [6:0] slot_q, done_slot_q;
  logic [6:0] sh_a_q, sh_b_q;
  logic [7:0] byte_a_q, byte_b_q;
  logic byte_done_q, fstart_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {i_flex_input_pin_b, i_flex_input_pin_a, i_frame_sync, i_bit_clock};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign bclk_rise = pin_s2_q[ftm_pkg::PIN_BCLK] && !bclk_prev_q;
  assign fstart = bclk_rise && pin_s2_q[ftm_pkg::PIN_FSYNC] && !fs_prev_q;

  // msb first; the frame's first bit comes with the rising sync
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bclk_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      bit_cnt_q <= '0;
      slot_q <= ftm_pkg::SLOT_LIMIT;
      sh_a_q <= '0;
      sh_b_q <= '0;
      byte_done_q <= 1'b0;
      fstart_q <= 1'b0;
      done_slot_q <= '0;
      byte_a_q <= '0;
      byte_b_q <= '0;
    end else begin
      bclk_prev_q <= pin_s2_q[ftm_pkg::PIN_BCLK];
      byte_done_q <= 1'b0;
      fstart_q <= fstart;
      if (bclk_rise) begin
        fs_prev_q <= pin_s2_q[ftm_pkg::PIN_FSYNC];
        sh_a_q <= {sh_a_q[5:0], pin_s2_q[ftm_pkg::PIN_A]};
        sh_b_q <= {sh_b_q[5:0], pin_s2_q[ftm_pkg::PIN_B]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (fstart) begin
          bit_cnt_q <= 3'h1;
          slot_q <= '0;
        end else if (bit_cnt_q == ftm_pkg::LAST_BIT) begin
          // slots past the table are ignored until the next frame
          byte_done_q <= !slot_q[6];
          done_slot_q <= slot_q;
          byte_a_q <= {sh_a_q, pin_s2_q[ftm_pkg::PIN_A]};
          byte_b_q <= {sh_b_q, pin_s2_q[ftm_pkg::PIN_B]};
          if (!slot_q[6]) begin
            slot_q <= slot_q + 7'h1;
          end
        end
      end
    end
  end

  // ****************************************
  // slot mapping
  // ****************************************
  ftm_pkg::ftm_map_entry_t ent;
  logic [7:0] raw_byte, put_byte;
  logic [3:0] wr_be;
  logic [3:0] wr_chan;
  logic wr_en;

  always_comb begin
    ent = map_q[done_slot_q[5:0]]; // RQ1
    raw_byte = ent.pin_sel ? byte_b_q : byte_a_q; // RQ5
    for (int i = 0; i < 8; i++) begin
      put_byte[i] = ent.reverse ? raw_byte[7-i] : raw_byte[i]; // RQ4
    end
    wr_en = byte_done_q && ent.enable; // RQ3
    wr_chan = {ent.pin_sel, ent.chan_pos}; // RQ6
    wr_be = ftm_pkg::LANE_TOP >> ent.byte_pos; // RQ7
  end

  // ****************************************
  // channel store and drain
  // ****************************************
  // drain of frame n overlaps the start of frame n+1; a long stall lets new bytes in
  ftm_pkg::ftm_drain_t drain_q;
  logic [3:0] rd_cnt_q, rd_chan_q;
  logic rd_pend_q, rd_en, pop;
  logic [31:0] ram_rdata;
  logic [1:0] cnt_q;
  ftm_pkg::ftm_chan_word_t buf_q [2];
  ftm_pkg::ftm_chan_word_t push_word;
  logic valid_q;

  assign rd_en = drain_q == ftm_pkg::FTM_DRAIN && ({1'b0, rd_pend_q} + cnt_q) < ftm_pkg::BUF_DEPTH;
  assign pop = valid_q && i_chan_ready;
  assign push_word = '{chan: ftm_pkg::CHAN_BASE + {2'h0, rd_chan_q}, data: ram_rdata};

  ftm_chan_ram u_ram (
    .i_clock(i_clock),
    .i_we(wr_en),
    .i_be(wr_be),
    .i_waddr(wr_chan),
    .i_wdata({4{put_byte}}),
    .i_re(rd_en),
    .i_raddr(rd_cnt_q),
    .o_rdata(ram_rdata)
  );

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drain_q <= ftm_pkg::FTM_IDLE;
      rd_cnt_q <= '0;
      rd_chan_q <= '0;
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_en;
      if (rd_en) begin
        rd_chan_q <= rd_cnt_q;
        rd_cnt_q <= rd_cnt_q + 4'h1;
      end
      unique case (drain_q)
        ftm_pkg::FTM_IDLE: begin
          if (fstart_q) begin
            drain_q <= ftm_pkg::FTM_DRAIN;
            rd_cnt_q <= '0;
          end
        end
        ftm_pkg::FTM_DRAIN: begin
          if (rd_en && rd_cnt_q == ftm_pkg::LAST_CHAN) begin
            drain_q <= ftm_pkg::FTM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      valid_q <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      cnt_q <= cnt_q + {1'b0, rd_pend_q} - {1'b0, pop};
      valid_q <= (cnt_q + {1'b0, rd_pend_q} - {1'b0, pop}) != 2'h0;
      if (pop) begin
        buf_q[0] <= (cnt_q == 2'h2) ? buf_q[1] : push_word;
        if (cnt_q == 2'h2 && rd_pend_q) begin
          buf_q[1] <= push_word;
        end
      end else if (rd_pend_q) begin
        if (cnt_q == 2'h0) begin
          buf_q[0] <= push_word;
        end else begin
          buf_q[1] <= push_word;
        end
      end
    end
  end

  assign o_chan_valid = valid_q;
  assign o_chan_word = buf_q[0];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  sequence s_write_taken;
    do_write && wlane_q && map_hit(awaddr_q);
  endsequence

  map_store_a: assert property ( // RQ2
    s_write_taken |=> map_q[$past(map_slot(awaddr_q))] == $past(wbyte_q))
    else $error("map entry not stored");
  slot_ignore_a: assert property (byte_done_q && !ent.enable |-> !wr_en) // RQ3
    else $error("disabled slot written");
  bit_mirror_a: assert property ( // RQ4
    wr_en && ent.reverse |-> put_byte == {raw_byte[0], raw_byte[1], raw_byte[2],
    raw_byte[3], raw_byte[4], raw_byte[5], raw_byte[6], raw_byte[7]})
    else $error("byte not mirrored");
  bit_keep_a: assert property (wr_en && !ent.reverse |-> put_byte == raw_byte) // RQ4
    else $error("byte altered");
  pin_group_a: assert property ( // RQ5
    wr_en |-> wr_chan[3] == ent.pin_sel && raw_byte == (ent.pin_sel ? byte_b_q : byte_a_q))
    else $error("wrong pin group");
  chan_pos_a: assert property (wr_en |-> wr_chan[2:0] == ent.chan_pos) // RQ6
    else $error("wrong channel position");
  byte_lane_a: assert property (wr_en && ent.byte_pos == 2'h0 |-> wr_be == 4'h8) // RQ7
    else $error("wrong byte lane");
  chan_range_a: assert property ( // RQ1
    o_chan_valid |-> o_chan_word.chan >= 6'h20 && o_chan_word.chan <= 6'h2f)
    else $error("channel out of range");
  bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (o_s_axi_arready && i_s_axi_arvalid |=>
    o_s_axi_rvalid ##0 !o_s_axi_arready)
    else $error("read not answered");
  buf_bound_a: assert property (cnt_q <= 2'h2 && !(cnt_q == 2'h2 && rd_pend_q && !pop))
    else $error("buffer overflow");
endmodule : ftm_mapper

// ### verif/ftm_tdm_source.sv
`timescale 1ns/10ps
module ftm_tdm_source (
  input wire logic i_clock,
  output logic o_bit_clock,
  output logic o_frame_sync,
  output logic o_pin_a,
  output logic o_pin_b
);
  logic [7:0] bytes_a [64];
  logic [7:0] bytes_b [64];

  initial begin
    o_bit_clock = 1'b0;
    o_frame_sync = 1'b0;
    o_pin_a = 1'b0;
    o_pin_b = 1'b1;
  end

  // ****************************************
  // frame sender
  // ****************************************
  // bit clock only runs inside a frame; msb first, same slot on both pins
  task automatic send_frame(input int n);
    for (int s = 0; s < n; s++) begin
      for (int i = 7; i >= 0; i--) begin
        @(posedge i_clock);
        o_pin_a <= bytes_a[s][i];
        o_pin_b <= bytes_b[s][i];
        o_frame_sync <= (s == 0);
        repeat (3) @(posedge i_clock);
        o_bit_clock <= 1'b1;
        repeat (4) @(posedge i_clock);
        o_bit_clock <= 1'b0;
      end
    end
    @(posedge i_clock);
    // released lines: no stale bit left for the receiver to reuse
    o_pin_a <= ~o_pin_a;
    o_pin_b <= ~o_pin_b;
    o_frame_sync <= 1'b0;
  endtask : send_frame
endmodule : ftm_tdm_source

// ### verif/flex_tdm_input_byte_mapper_tb.sv
`timescale 1ns/10ps
module flex_tdm_input_byte_mapper_tb;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic bclk, fsync, pin_a, pin_b;
  logic [17:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, i_chan_ready = 1'b0;
  logic [31:0] i_s_axi_wdata = '0;
  logic [3:0] i_s_axi_wstrb = '0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata;
  logic o_chan_valid;
  ftm_pkg::ftm_chan_word_t o_chan_word;
  logic [31:0] got [16];
  int fails = 0, n_tests = 0, n_words = 0;

  always #20 i_clock = ~i_clock;

  ftm_tdm_source src (.i_clock, .o_bit_clock(bclk), .o_frame_sync(fsync),
    .o_pin_a(pin_a), .o_pin_b(pin_b));

  ftm_mapper DUT (.i_clock, .i_reset_n, .i_bit_clock(bclk), .i_frame_sync(fsync),
    .i_flex_input_pin_a(pin_a), .i_flex_input_pin_b(pin_b), .i_s_axi_awaddr,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
    .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready, .o_chan_valid, .o_chan_word, .i_chan_ready);

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic guard(input int n);
    if (n >= 200) begin
      fails++;
      $display("[ERR] %0t bus wait ran out", $time);
      close_out();
    end
  endtask : guard

  task automatic axw(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er,
    input logic [3:0] st = 4'hf);
    int n = 0;
    i_s_axi_awaddr <= {idx, 2'h0};
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wdata <= d;
    i_s_axi_wstrb <= st;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      n++;
    end while (!o_s_axi_bvalid && n < 200);
    guard(n);
    chk({30'h0, o_s_axi_bresp}, {30'h0, er});
    i_s_axi_bready <= 1'b0;
    // one edge between transfers, so no handshake line is set twice at once
    @(posedge i_clock);
  endtask : axw

  task automatic axr(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    i_s_axi_araddr <= {idx, 2'h0};
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      n++;
    end while (!o_s_axi_rvalid && n < 200);
    guard(n);
    chk(o_s_axi_rdata, ed);
    chk({30'h0, o_s_axi_rresp}, {30'h0, er});
    i_s_axi_rready <= 1'b0;
    @(posedge i_clock);
  endtask : axr

  function automatic logic [7:0] pa(input int k, input int f);
    return 8'(8'h13 + k * 29 + f * 90);
  endfunction : pa

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction : rev

  task automatic frame(input int f, input int n);
    for (int k = 0; k < 64; k++) begin
      src.bytes_a[k] = pa(k, f);
      src.bytes_b[k] = ~pa(k, f);
    end
    src.send_frame(n);
    repeat (8) @(posedge i_clock);
  endtask : frame

  // ****************************************
  // channel stream sink
  // ****************************************
  // receiver stalls every other cycle to exercise the two-entry buffer
  always @(posedge i_clock) begin
    i_chan_ready <= ~i_chan_ready;
    if (o_chan_valid && i_chan_ready) begin
      chk({26'h0, o_chan_word.chan}, 32'(32 + n_words % 16));
      got[o_chan_word.chan[3:0]] = o_chan_word.data;
      n_words++;
    end
  end

  initial begin
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    axr(16'hf300, 32'h0, ftm_pkg::RESP_OKAY);
    axr(16'hf33f, 32'h0, ftm_pkg::RESP_OKAY);
    axr(16'hf340, 32'h0, ftm_pkg::RESP_SLVERR);
    axw(16'hf340, 32'h1, ftm_pkg::RESP_SLVERR);
    axw(16'hf33f, 32'h1ff, ftm_pkg::RESP_OKAY);
    axr(16'hf33f, 32'hff, ftm_pkg::RESP_OKAY);
    axw(16'hf33f, 32'h0, ftm_pkg::RESP_OKAY, 4'h0);
    axr(16'hf33f, 32'hff, ftm_pkg::RESP_OKAY);
    $display("test registers done");
    // slot map: 0 a/ch32/lane0, 1 rev b/ch47/lane3, 2 a/ch32/lane2, 3 a/ch35/lane1,
    // 4 b/ch42/lane2, 5 and 6 both a/ch32/lane1
    axw(16'hf300, 32'h80, ftm_pkg::RESP_OKAY);
    axw(16'hf301, 32'hff, ftm_pkg::RESP_OKAY);
    axw(16'hf302, 32'h82, ftm_pkg::RESP_OKAY);
    axw(16'hf303, 32'h8d, ftm_pkg::RESP_OKAY);
    axw(16'hf304, 32'haa, ftm_pkg::RESP_OKAY);
    axw(16'hf305, 32'h81, ftm_pkg::RESP_OKAY);
    axw(16'hf306, 32'h81, ftm_pkg::RESP_OKAY);
    frame(0, 7);
    axw(16'hf300, 32'h0, ftm_pkg::RESP_OKAY);
    axw(16'hf302, 32'h02, ftm_pkg::RESP_OKAY);
    frame(1, 7);
    chk({24'h0, got[0][31:24]}, {24'h0, pa(0, 0)});
    chk({24'h0, got[0][23:16]}, {24'h0, pa(6, 0)});
    chk({24'h0, got[0][15:8]}, {24'h0, pa(2, 0)});
    chk({24'h0, got[15][7:0]}, {24'h0, rev(~pa(1, 0))});
    chk({24'h0, got[3][23:16]}, {24'h0, pa(3, 0)});
    chk({24'h0, got[10][15:8]}, {24'h0, ~pa(4, 0)});
    $display("test first frame done");
    frame(2, 1);
    chk({24'h0, got[0][31:24]}, {24'h0, pa(0, 0)});
    chk({24'h0, got[0][15:8]}, {24'h0, pa(2, 0)});
    chk({24'h0, got[0][23:16]}, {24'h0, pa(6, 1)});
    chk({24'h0, got[15][7:0]}, {24'h0, rev(~pa(1, 1))});
    chk(32'(n_words), 32'd48);
    $display("test second frame done");
    close_out();
  end
endmodule : flex_tdm_input_byte_mapper_tb
